// ---- shared/adc_seq_pkg.sv ----
// constants shared by the scan group sequencer: register map, control field
// positions, reset values, channel codes and conversion timing.
// assumes a 40 MHz core clock that also serves as the peripheral bus clock.
`default_nettype none

package adc_seq_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHSEL_A = 8'h04;
	localparam logic [7:0] OFS_CHSEL_B = 8'h08;
	localparam logic [7:0] OFS_CHSEL_C = 8'h0c;
	localparam logic [7:0] OFS_DBL_CH = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_STATE = 8'h1c;
	localparam logic [7:0] OFS_DATA0 = 8'h40;
	localparam logic [7:0] OFS_DUP = 8'h98;
	localparam logic [7:0] OFS_DUP_EXT0 = 8'h9c;
	localparam logic [7:0] OFS_DUP_EXT1 = 8'ha0;
	localparam logic [7:0] OFS_VREF = 8'ha4;
	localparam logic [7:0] OFS_DIAG = 8'ha8;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTL_MODE = 0;
	localparam int CTL_THREE = 2;
	localparam int CTL_PRIO = 3;
	localparam int CTL_RESCAN = 4;
	localparam int CTL_FROM_NEXT = 5;
	localparam int CTL_ADD = 6;
	localparam int CTL_ADD4 = 7;
	localparam int CTL_DBL = 8;
	localparam int CTL_DBL_EXT = 9;
	localparam int CTL_VREF = 10;
	localparam int CTL_DIAG = 11;
	localparam int CTL_RATIO = 12;
	localparam int CTL_START = 15;
	localparam int CTL_STOP = 16;
	localparam int CTL_W = 15;
	localparam logic [CTL_W-1:0] CTRL_RESET = 15'h0000;

	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h1;
	localparam logic [1:0] MODE_GROUP = 2'h2;

	// peripheral clock : conversion clock ratios
	localparam logic [2:0] RATIO_1_1 = 3'h0;
	localparam logic [2:0] RATIO_1_2 = 3'h1;
	localparam logic [2:0] RATIO_2_1 = 3'h2;
	localparam logic [2:0] RATIO_4_1 = 3'h3;
	localparam logic [2:0] RATIO_8_1 = 3'h4;

	// ----------------------------------------------------------------
	// channels and results
	// ----------------------------------------------------------------
	localparam int NUM_CH = 22;
	localparam logic [4:0] CH_VREF = 5'h16;
	localparam logic [4:0] CH_DIAG = 5'h17;
	localparam int RES_W = 12;
	localparam int SUM_W = 16;
	localparam int ST_W = 4;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CONV_TIME_NS = 1000;
	localparam int CONV_CLK_MHZ = 40;
	localparam int CONV_CYCLES = (CONV_TIME_NS * CONV_CLK_MHZ) / 1000;
endpackage : adc_seq_pkg

`default_nettype wire

// ---- core/adc_scan_group_sequencer.sv ----
// scan group sequencer for one 12-bit successive-approximation converter unit.
// assumes an analog front end that samples conv_chan_o one cycle after conv_sample_o and
// holds a settled conv_data_i when the conversion time has elapsed.
`default_nettype none

module adc_scan_group_sequencer #(
	parameter int UNIT_ID = 0
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [adc_seq_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [2:0] group_trig_i,
	input wire logic [1:0] ext_trig_i,
	input wire logic [adc_seq_pkg::RES_W-1:0] conv_data_i,
	output logic [4:0] conv_chan_o,
	output logic conv_sample_o,
	output logic busy_o,
	output logic irq_o
);
	import adc_seq_pkg::*;

	typedef enum logic [0:0] {S_IDLE, S_CONV} seq_state_t;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// first set bit at or above 'from'; bit 5 flags that one was found
	function automatic logic [5:0] first_set(input logic [23:0] m, input logic [4:0] from);
		logic [5:0] r;
		r = 6'h00;
		for (int i = 23; i >= 0; i--) begin
			if (m[i] && (5'(i) >= from)) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction : first_set

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [CTL_W-1:0] ctrl;
	logic [NUM_CH-1:0] chsel [3];
	logic [4:0] dbl_ch;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] irq_mask;
	logic [SUM_W-1:0] data_reg [NUM_CH];
	logic [SUM_W-1:0] dup_reg;
	logic [SUM_W-1:0] dup_ext [2];
	logic [SUM_W-1:0] vref_reg;
	logic [SUM_W-1:0] diag_reg;

	seq_state_t state;
	logic [1:0] grp;
	logic [4:0] ch;
	logic [5:0] cyc;
	logic [3:0] rep;
	logic [SUM_W-1:0] acc;
	logic [2:0] pend;
	logic [4:0] resume_pos [3];
	logic dbl_second;
	logic ext_src_vld;
	logic ext_src;
	logic [2:0] div_cnt;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire [1:0] mode = ctrl[CTL_MODE +: 2];
	wire group_mode = (mode == MODE_GROUP);
	wire three_grp = ctrl[CTL_THREE];
	wire prio_en = ctrl[CTL_PRIO];
	wire rescan_en = ctrl[CTL_RESCAN];
	wire from_next = ctrl[CTL_FROM_NEXT];
	wire add_en = ctrl[CTL_ADD];
	wire [2:0] ratio = ctrl[CTL_RATIO +: 3];
	// the third unit alone owns the internal reference path
	wire vref_ok = (UNIT_ID == 2) && ctrl[CTL_VREF] && (mode == MODE_SINGLE);

	wire wr_en = psel_i && penable_i && pwrite_i && !pready_o;
	wire rd_en = psel_i && penable_i && !pwrite_i && !pready_o;
	wire wr_ctrl = wr_en && (paddr_i == OFS_CTRL);
	wire sw_start = wr_ctrl && pwdata_i[CTL_START];
	wire sw_stop = wr_ctrl && pwdata_i[CTL_STOP];
	wire rd_status = rd_en && (paddr_i == OFS_STATUS);

	// conversion clock as an enable; 1:2 cannot beat the core clock, so it
	// runs at the same rate as 1:1 and the conversion time stays the same
	wire [2:0] div_max = (ratio == RATIO_2_1) ? 3'h1 :
		(ratio == RATIO_4_1) ? 3'h3 :
		(ratio == RATIO_8_1) ? 3'h7 : 3'h0;
	wire conv_en = (div_cnt == div_max);

	// group A is served by trigger A and by the extended double triggers
	wire ext_any = |ext_trig_i;
	wire [2:0] grp_hit = group_mode ? {group_trig_i[2] && three_grp, group_trig_i[1],
		group_trig_i[0] || ext_any || sw_start} : 3'h0;
	wire scan_req = !group_mode && (sw_start || group_trig_i[0] || ext_any);

	wire [1:0] top_grp = pend[0] ? 2'h0 : pend[1] ? 2'h1 : 2'h2;
	wire preempt = (state == S_CONV) && group_mode && prio_en &&
		(grp != 2'h3) && (top_grp < grp) && (|pend);

	wire [23:0] scan_mask = {ctrl[CTL_DIAG], vref_ok, chsel[0]};
	wire [23:0] cur_mask = (grp == 2'h3) ? scan_mask : {2'h0, chsel[grp]};
	wire [23:0] top_mask = {2'h0, chsel[top_grp]};
	wire [5:0] scan_first = first_set(scan_mask, 5'h00);
	wire [5:0] top_first = first_set(top_mask, resume_pos[top_grp]);
	wire [5:0] nxt = first_set(cur_mask, ch + 5'h01);

	wire [3:0] rep_max = !add_en ? 4'h0 : ctrl[CTL_ADD4] ? 4'hf : 4'h3;
	wire conv_end = (state == S_CONV) && conv_en && (cyc == 6'(CONV_CYCLES - 1));
	wire [SUM_W-1:0] sum = acc + SUM_W'(conv_data_i);
	wire ch_done = conv_end && (rep == rep_max);
	wire pass_end = ch_done && !nxt[5];

	// where a finished result lands
	wire dbl_hit = ctrl[CTL_DBL] && (mode != MODE_CONT) && (ch == dbl_ch);
	wire to_ext = dbl_hit && ctrl[CTL_DBL_EXT] && ext_src_vld;
	wire to_dup = dbl_hit && !to_ext && dbl_second;

	// done events: bit 0 plain scan pass, bits 1..3 groups A..C
	wire [ST_W-1:0] evt = !pass_end ? 4'h0 :
		(grp == 2'h3) ? 4'h1 : 4'(4'h2 << grp);

	// ----------------------------------------------------------------
	// register read mux
	// ----------------------------------------------------------------
	wire [5:0] word = paddr_i[7:2];
	wire [5:0] data_idx = word - 6'h10;
	wire data_hit = (paddr_i >= OFS_DATA0) && (paddr_i < OFS_DUP) && (paddr_i[1:0] == 2'h0);
	wire [31:0] rd_data =
		(paddr_i == OFS_CTRL) ? 32'(ctrl) :
		(paddr_i == OFS_CHSEL_A) ? 32'(chsel[0]) :
		(paddr_i == OFS_CHSEL_B) ? 32'(chsel[1]) :
		(paddr_i == OFS_CHSEL_C) ? 32'(chsel[2]) :
		(paddr_i == OFS_DBL_CH) ? 32'(dbl_ch) :
		(paddr_i == OFS_STATUS) ? 32'(status) :
		(paddr_i == OFS_MASK) ? 32'(irq_mask) :
		(paddr_i == OFS_STATE) ? {21'h0, pend, grp, ch, (state == S_CONV)} :
		data_hit ? 32'(data_reg[data_idx[4:0]]) :
		(paddr_i == OFS_DUP) ? 32'(dup_reg) :
		(paddr_i == OFS_DUP_EXT0) ? 32'(dup_ext[0]) :
		(paddr_i == OFS_DUP_EXT1) ? 32'(dup_ext[1]) :
		(paddr_i == OFS_VREF) ? 32'(vref_reg) :
		(paddr_i == OFS_DIAG) ? 32'(diag_reg) : 32'h0000_0000;
	wire mapped = data_hit || (paddr_i <= OFS_STATE && paddr_i[1:0] == 2'h0) ||
		(paddr_i >= OFS_DUP && paddr_i <= OFS_DIAG && paddr_i[1:0] == 2'h0);

	// ----------------------------------------------------------------
	// bus slave: one wait state, every access answered
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= psel_i && penable_i && !pready_o;
			pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
			prdata_o <= rd_en ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctrl <= CTRL_RESET;
			chsel <= '{default: '0};
			dbl_ch <= 5'h00;
			irq_mask <= 4'h0;
		end else if (wr_en) begin
			if (paddr_i == OFS_CTRL) ctrl <= pwdata_i[CTL_W-1:0];
			if (paddr_i == OFS_CHSEL_A) chsel[0] <= pwdata_i[NUM_CH-1:0];
			if (paddr_i == OFS_CHSEL_B) chsel[1] <= pwdata_i[NUM_CH-1:0];
			if (paddr_i == OFS_CHSEL_C) chsel[2] <= pwdata_i[NUM_CH-1:0];
			if (paddr_i == OFS_DBL_CH) dbl_ch <= pwdata_i[4:0];
			if (paddr_i == OFS_MASK) irq_mask <= pwdata_i[ST_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// interrupt: read clears, a new event in the same cycle survives
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			status <= 4'h0;
			irq_o <= 1'b0;
		end else begin
			status <= (rd_status ? 4'h0 : status) | evt;
			irq_o <= |(((rd_status ? 4'h0 : status) | evt) & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// conversion clock divider
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i || conv_en) begin
			div_cnt <= 3'h0;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			state <= S_IDLE;
			grp <= 2'h3;
			ch <= 5'h00;
			cyc <= 6'h00;
			rep <= 4'h0;
			acc <= 16'h0000;
			pend <= 3'h0;
			resume_pos <= '{default: '0};
			dbl_second <= 1'b0;
			ext_src_vld <= 1'b0;
			ext_src <= 1'b0;
			conv_sample_o <= 1'b0;
		end else begin
			conv_sample_o <= 1'b0;
			pend <= pend | grp_hit;
			if (ext_any && (state == S_IDLE)) begin
				ext_src_vld <= 1'b1;
				ext_src <= ext_trig_i[1];
			end
			if (sw_stop) begin
				state <= S_IDLE;
				pend <= 3'h0;
				dbl_second <= 1'b0;
				ext_src_vld <= 1'b0;
			end else if (state == S_IDLE) begin
				if (scan_req && scan_first[5]) begin
					state <= S_CONV;
					grp <= 2'h3;
					ch <= scan_first[4:0];
					conv_sample_o <= 1'b1;
				end else if (|pend) begin
					pend[top_grp] <= grp_hit[top_grp];
					resume_pos[top_grp] <= 5'h00;
					grp <= top_grp;
					ch <= top_first[4:0];
					state <= top_first[5] ? S_CONV : S_IDLE;
					conv_sample_o <= top_first[5];
				end
				cyc <= 6'h00;
				rep <= 4'h0;
				acc <= 16'h0000;
			end else if (preempt) begin
				// with rescan enabled the aborted group's partial channel is redone
				if (rescan_en) begin
					pend[grp] <= 1'b1;
					resume_pos[grp] <= from_next ? ch : 5'h00;
				end
				pend[top_grp] <= grp_hit[top_grp];
				resume_pos[top_grp] <= 5'h00;
				grp <= top_grp;
				ch <= top_first[4:0];
				state <= top_first[5] ? S_CONV : S_IDLE;
				conv_sample_o <= top_first[5];
				cyc <= 6'h00;
				rep <= 4'h0;
				acc <= 16'h0000;
			end else if (conv_en) begin
				cyc <= conv_end ? 6'h00 : cyc + 6'h01;
				if (conv_end) begin
					rep <= ch_done ? 4'h0 : rep + 4'h1;
					acc <= ch_done ? 16'h0000 : sum;
					conv_sample_o <= 1'b1;
					if (ch_done && dbl_hit && !to_ext) dbl_second <= !dbl_second;
					if (ch_done && nxt[5]) begin
						ch <= nxt[4:0];
					end else if (pass_end) begin
						ext_src_vld <= 1'b0;
						if (mode == MODE_CONT && grp == 2'h3 && scan_first[5]) begin
							ch <= scan_first[4:0];
						end else begin
							state <= S_IDLE;
							conv_sample_o <= 1'b0;
						end
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// result storage
	// ----------------------------------------------------------------
	wire [SUM_W-1:0] result = add_en ? sum : SUM_W'(conv_data_i);

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			data_reg <= '{default: '0};
			dup_reg <= 16'h0000;
			dup_ext <= '{default: '0};
			vref_reg <= 16'h0000;
			diag_reg <= 16'h0000;
		end else if (ch_done && !preempt && !sw_stop) begin
			if (ch == CH_VREF) begin
				vref_reg <= result;
			end else if (ch == CH_DIAG) begin
				diag_reg <= result;
			end else if (to_ext) begin
				dup_ext[ext_src] <= result;
			end else if (to_dup) begin
				dup_reg <= result;
			end else begin
				data_reg[ch] <= result;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			conv_chan_o <= 5'h00;
			busy_o <= 1'b0;
		end else begin
			conv_chan_o <= ch;
			busy_o <= (state == S_CONV);
		end
	end
endmodule : adc_scan_group_sequencer

`default_nettype wire

// ---- tb/afe_model.sv ----
// analog front end model: answers each sample with bias plus channel.
// assumes the sequencer reads conv_data_i once the conversion time is over.
`default_nettype none
module afe_model (
	input wire logic core_clk_i,
	input wire logic conv_sample_i,
	input wire logic [4:0] conv_chan_i,
	input wire logic [11:0] bias_i,
	output logic [11:0] conv_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sample_d = 1'b0;
	initial conv_data_o = 12'h000;
	// one 12-bit code per channel, so a swapped register shows up;
	// the channel output trails the sample pulse by a cycle, so wait for it
	always @(posedge core_clk_i) begin
		sample_d <= conv_sample_i;
		if (sample_d) begin
			conv_data_o <= bias_i + 12'(conv_chan_i);
		end
	end
endmodule : afe_model
`default_nettype wire

// ---- tb/adc_seq_checker.sv ----
// port assertions for the sequencer: bus handshake, sample pulses, reset.
// assumes it is bound to every sequencer instance.
`default_nettype none
module adc_seq_checker (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [4:0] conv_chan_o,
	input wire logic conv_sample_o,
	input wire logic busy_o,
	input wire logic irq_o
);
	import adc_seq_pkg::*;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (srst_i);
	a_ready_one_wait: assert property (psel_i && penable_i && !$past(penable_i) |=> pready_o)
		else $error("ready not one cycle after access");
	a_ready_one_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
		else $error("read data outside ready");
	a_sample_one_pulse: assert property (conv_sample_o |=> !conv_sample_o)
		else $error("sample pulse too long");
	a_sample_sets_busy: assert property (conv_sample_o |-> ##[0:1] busy_o)
		else $error("sample without busy");
	a_chan_in_range: assert property (busy_o |-> conv_chan_o <= CH_DIAG)
		else $error("channel out of range");
	a_reset_quiet: assert property ($fell(srst_i) |-> !busy_o && !irq_o && !pready_o)
		else $error("outputs active after reset");
endmodule : adc_seq_checker
bind adc_scan_group_sequencer adc_seq_checker u_adc_seq_checker (.core_clk_i, .srst_i,
	.psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o, .conv_chan_o, .conv_sample_o,
	.busy_o, .irq_o);
`default_nettype wire

// ---- tb/adc_scan_group_sequencer_bench.sv ----
// self-checking bench for the scan group sequencer, driven over apb.
// assumes the afe model answers every sample with bias plus channel.
`default_nettype none
module adc_scan_group_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import adc_seq_pkg::*;
	logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] gtrig = 3'h0;
	logic [1:0] etrig = 2'h0;
	logic [11:0] bias = 12'h100, cdata;
	logic [4:0] chan;
	logic pready, pslverr, serr, busy, irq, sample;
	int n_fail = 0, tests_run = 0, cyc = 0, t;
	int dv[5] = '{1, 1, 2, 4, 8};
	always #12.5 clk = ~clk;
	adc_scan_group_sequencer #(.UNIT_ID(2)) u_adc_scan_group_sequencer (.core_clk_i(clk),
		.srst_i(srst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.group_trig_i(gtrig), .ext_trig_i(etrig), .conv_data_i(cdata), .conv_chan_o(chan),
		.conv_sample_o(sample), .busy_o(busy), .irq_o(irq));
	afe_model u_afe_model (.core_clk_i(clk), .conv_sample_i(sample), .conv_chan_i(chan),
		.bias_i(bias), .conv_data_o(cdata));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdc
	task wait_irq();
		t = 0;
		while (irq !== 1'b1 && t < 2000) begin
			@(posedge clk);
			t++;
		end
		if (t >= 2000) begin
			n_fail++;
			tally_and_finish();
		end
	endtask : wait_irq
	task pulse(input logic [2:0] g, input logic [1:0] e);
		gtrig <= g;
		etrig <= e;
		@(posedge clk);
		gtrig <= 3'h0;
		etrig <= 2'h0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rdc(OFS_CTRL, 32'h0);
		rdc(8'h30, 32'h0);
		check(serr, 1'b1);
		apb(1'b1, OFS_MASK, 32'hf);
		apb(1'b1, OFS_CHSEL_A, 32'h20_0001);
		apb(1'b1, OFS_CTRL, 32'h8000);
		wait_irq();
		rdc(OFS_DATA0, 32'h100);
		rdc(OFS_DATA0 + 8'h54, 32'h115);
		rdc(OFS_STATUS, 32'h1);
		rdc(OFS_STATUS, 32'h0);
		check(irq, 1'b0);
		apb(1'b1, OFS_CHSEL_A, 32'h8);
		for (int r = 0; r < 5; r++) begin
			apb(1'b1, OFS_CTRL, 32'h8000 | 32'(r << 12));
			wait_irq();
			check(t >= CONV_CYCLES * dv[r] - 4 && t <= CONV_CYCLES * dv[r] + 6, 1'b1);
			rdc(OFS_STATUS, 32'h1);
		end
		apb(1'b1, OFS_CTRL, 32'h8040);
		wait_irq();
		rdc(OFS_DATA0 + 8'h0c, 32'h40c);
		rdc(OFS_STATUS, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h80c0);
		wait_irq();
		rdc(OFS_DATA0 + 8'h0c, 32'h1030);
		rdc(OFS_STATUS, 32'h1);
		apb(1'b1, OFS_DBL_CH, 32'h3);
		apb(1'b1, OFS_CTRL, 32'h8100);
		wait_irq();
		rdc(OFS_STATUS, 32'h1);
		bias <= 12'h200;
		apb(1'b1, OFS_CTRL, 32'h8100);
		wait_irq();
		rdc(OFS_DATA0 + 8'h0c, 32'h103);
		rdc(OFS_DUP, 32'h203);
		rdc(OFS_STATUS, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h300);
		pulse(3'h0, 2'h2);
		wait_irq();
		rdc(OFS_DUP_EXT1, 32'h203);
		rdc(OFS_STATUS, 32'h1);
		bias <= 12'h300;
		pulse(3'h0, 2'h1);
		wait_irq();
		rdc(OFS_DUP_EXT0, 32'h303);
		rdc(OFS_DUP_EXT1, 32'h203);
		rdc(OFS_STATUS, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h8001);
		wait_irq();
		rdc(OFS_STATUS, 32'h1);
		wait_irq();
		check(irq, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h10001);
		repeat (100) @(posedge clk);
		check(busy, 1'b0);
		rdc(OFS_STATUS, 32'h1);
		apb(1'b1, OFS_CHSEL_A, 32'h2);
		apb(1'b1, OFS_CHSEL_B, 32'hf0);
		apb(1'b1, OFS_CHSEL_C, 32'h600);
		apb(1'b1, OFS_CTRL, 32'h1e);
		pulse(3'h2, 2'h0);
		repeat (60) @(posedge clk);
		pulse(3'h1, 2'h0);
		check(chan, 32'h1);
		repeat (400) @(posedge clk);
		rdc(OFS_STATUS, 32'h6);
		rdc(OFS_DATA0 + 8'h1c, 32'h307);
		apb(1'b1, OFS_CTRL, 32'h0e);
		pulse(3'h4, 2'h0);
		repeat (60) @(posedge clk);
		pulse(3'h1, 2'h0);
		repeat (300) @(posedge clk);
		rdc(OFS_STATUS, 32'h2);
		// rescan from the next channel: channel 4 keeps its old code
		apb(1'b1, OFS_CTRL, 32'h3e);
		pulse(3'h2, 2'h0);
		repeat (60) @(posedge clk);
		pulse(3'h1, 2'h0);
		bias <= 12'h400;
		repeat (300) @(posedge clk);
		rdc(OFS_DATA0 + 8'h10, 32'h304);
		rdc(OFS_DATA0 + 8'h14, 32'h405);
		rdc(OFS_STATUS, 32'h6);
		bias <= 12'h300;
		apb(1'b1, OFS_MASK, 32'h0);
		// a start acts on the mode already stored, so set the mode first
		apb(1'b1, OFS_CTRL, 32'h0c00);
		apb(1'b1, OFS_CTRL, 32'h8c00);
		repeat (300) @(posedge clk);
		check(irq, 1'b0);
		rdc(OFS_VREF, 32'h316);
		rdc(OFS_DIAG, 32'h317);
		rdc(OFS_STATUS, 32'h1);
		tally_and_finish();
	end
endmodule : adc_scan_group_sequencer_bench
`default_nettype wire
